/* File: src/mbf_handler.sv */
// Purpose: Modbus function 0x17, 0x67, 0x68 server handler
// Assumes: Request PDU bytes in, response PDU bytes out, one per cycle
// Notes: Responses are streamed only after the request is complete
`timescale 1ns/10ps
module mbf_handler import mbf_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Request stream
    input wire mbf_byte_type req,
    // Response stream
    output mbf_byte_type rsp,
    // Status
    output logic busy
);
    // ************************************************************
    // Declarations
    // ************************************************************
    typedef enum logic [2:0] {
        ST_RX, ST_WRITE, ST_ERR, ST_TX, ST_DRAIN
    } mbf_state_type;

    mbf_state_type st_q, st_d;
    logic [7:0] buf_q [256]; // Captured request bytes
    logic [7:0] buf_d [256];
    logic [7:0] len_q, len_d; // Request length in bytes
    logic [7:0] idx_q, idx_d; // Byte index (rx, write, tx)
    logic [7:0] exc_q, exc_d; // Exception code
    mbf_byte_type rsp_q, rsp_d;
    logic wr_en;
    logic [15:0] wr_addr, wr_data, rd_addr, rd_data;
    logic rd_hit;
    logic [7:0] fc;
    logic [15:0] ra, rq, wa, wq;
    logic [7:0] tx_len;

    // Big-endian 16-bit field from the request buffer
    function automatic logic [15:0] fld(input logic [7:0] hi,
                                        input logic [7:0] lo);
        return {hi, lo};
    endfunction

    assign fc = buf_q[0];
    assign ra = fld(buf_q[1], buf_q[2]);
    assign rq = fld(buf_q[3], buf_q[4]);
    assign wa = fld(buf_q[5], buf_q[6]);
    assign wq = fld(buf_q[7], buf_q[8]);

    // Register storage
    mbf_regfile #(.WORDS(TAB_WORDS)) u_regs (
        .core_clk(core_clk),
        .resetn(resetn),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    // ************************************************************
    // Write and read address generation
    // ************************************************************
    // Addresses are used as sent: zero-based register numbers
    always_comb begin
        wr_en = 1'b0;
        wr_addr = 16'h0000;
        wr_data = 16'h0000;
        if (st_q == ST_WRITE) begin
            wr_en = 1'b1;
            if (fc == FC_FWR) begin
                // Float write: two registers hold one 32-bit value
                wr_addr = ra + 16'(idx_q);
                wr_data = fld(buf_q[3 + 2 * idx_q], buf_q[4 + 2 * idx_q]);
            end else begin
                wr_addr = wa + 16'(idx_q);
                wr_data = fld(buf_q[10 + 2 * idx_q], buf_q[11 + 2 * idx_q]);
            end
        end
    end

    // Read address follows the response byte being emitted
    always_comb begin
        if (idx_q >= 8'd2) begin
            rd_addr = ra + 16'((idx_q - 8'd2) >> 1);
        end else begin
            rd_addr = ra;
        end
    end

    // Response length: echo, or code+count+2N
    always_comb begin
        if (fc == FC_FWR) begin
            tx_len = len_q;
        end else begin
            tx_len = 8'(8'd2 + 2 * rq[6:0]);
        end
    end

    // ************************************************************
    // Control state machine
    // ************************************************************
    always_comb begin
        st_d = st_q;
        len_d = len_q;
        idx_d = idx_q;
        exc_d = exc_q;
        rsp_d = '0;
        for (int i = 0; i < 256; i++) begin
            buf_d[i] = buf_q[i];
        end
        unique case (st_q)
            ST_RX: begin
                if (req.valid) begin
                    buf_d[idx_q] = req.data;
                    idx_d = idx_q + 8'd1;
                    if (req.last) begin
                        len_d = idx_q + 8'd1;
                        idx_d = 8'd0;
                        st_d = ST_ERR;
                    end
                end
            end
            ST_ERR: begin
                // Validate request before touching storage
                st_d = ST_WRITE;
                exc_d = 8'h00;
                if (fc == FC_FWR) begin
                    if (len_q != 8'd7) exc_d = EXC_VALUE;
                end else if (fc == FC_FRD) begin
                    st_d = ST_TX;
                    if (len_q != 8'd5 || rq == 16'h0000 ||
                        rq > MAX_QTY_FRD) exc_d = EXC_VALUE;
                end else if (fc == FC_RDWR) begin
                    if (rq == 16'h0000 || rq > MAX_QTY_RDWR ||
                        wq == 16'h0000 || wq > MAX_QTY_RDWR ||
                        buf_q[9] != 8'(2 * wq[6:0]) ||
                        len_q != 8'(8'd10 + buf_q[9])) exc_d = EXC_VALUE;
                end else begin
                    exc_d = EXC_FUNC;
                end
                if (exc_d != 8'h00) st_d = ST_TX;
            end
            ST_WRITE: begin
                // Store first; reads and echo follow only once stored
                idx_d = idx_q + 8'd1;
                if ((fc == FC_FWR && idx_q == 8'd1) ||
                    (fc == FC_RDWR && idx_q == 8'(wq - 16'd1))) begin
                    idx_d = 8'd0;
                    st_d = ST_TX;
                end
            end
            ST_TX: begin
                rsp_d.valid = 1'b1;
                idx_d = idx_q + 8'd1;
                if (exc_q != 8'h00) begin
                    // Error: code with bit 7 set, then exception
                    rsp_d.data = (idx_q == 8'd0) ? (fc | ERR_BIT) : exc_q;
                    rsp_d.last = (idx_q == 8'd1);
                end else if (fc == FC_FWR) begin
                    rsp_d.data = buf_q[idx_q];
                    rsp_d.last = (idx_q == tx_len - 8'd1);
                end else begin
                    if (idx_q == 8'd0) begin
                        rsp_d.data = fc;
                    end else if (idx_q == 8'd1) begin
                        rsp_d.data = 8'(2 * rq[6:0]);
                    end else if (!rd_hit) begin
                        rsp_d.data = 8'h00;
                    end else if (idx_q[0] == 1'b0) begin
                        rsp_d.data = rd_data[15:8];
                    end else begin
                        rsp_d.data = rd_data[7:0];
                    end
                    rsp_d.last = (idx_q == tx_len - 8'd1);
                end
                if (rsp_d.last) st_d = ST_DRAIN;
            end
            ST_DRAIN: begin
                idx_d = 8'd0;
                exc_d = 8'h00;
                st_d = ST_RX;
            end
            default: st_d = ST_RX;
        endcase
    end

    // Registers of the control path
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_q <= ST_RX;
            len_q <= 8'h00;
            idx_q <= 8'h00;
            exc_q <= 8'h00;
            rsp_q <= '0;
        end else begin
            st_q <= st_d;
            len_q <= len_d;
            idx_q <= idx_d;
            exc_q <= exc_d;
            rsp_q <= rsp_d;
        end
    end

    // Request buffer is data only, no reset needed for function
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 256; i++) begin
            buf_q[i] <= buf_d[i];
        end
    end

    // Busy flag follows the next state, so it leaves a flop in step
    logic busy_q, busy_d;
    always_comb begin
        busy_d = (st_d != ST_RX);
    end

    // Busy register
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
        end
    end

    assign rsp = rsp_q;
    assign busy = busy_q;

endmodule // mbf_handler

/* File: src/mbf_pkg.sv */
// Purpose: Shared constants and types for the Modbus float register handler
// Assumes: PDU bytes arrive one per cycle, MBAP header already removed
// Notes: Rules carried by the handler are listed below
// Operation
// - Read/write reply: code, 2N count, data
// - Float read returns contiguous block from address
// - Each float parameter holds 32-bit float
// - PDU register addresses are zero-based
// - Reply packs two bytes per register
// - High byte first, low byte second
// - Successful float write echoes request
// - Echo only after value is stored
// - Read/write does write before read
package mbf_pkg;

    // ************************************************************
    // Function and exception codes
    // ************************************************************
    localparam logic [7:0] FC_RDWR = 8'h17;
    localparam logic [7:0] FC_FRD = 8'h67;
    localparam logic [7:0] FC_FWR = 8'h68;
    localparam logic [7:0] ERR_BIT = 8'h80;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;

    // ************************************************************
    // Parameter table layout
    // ************************************************************
    // Base of the float table; each float spans two 16-bit registers
    localparam logic [15:0] TAB_BASE = 16'he000;
    localparam logic [15:0] GAS_PREFLOW_TIME = 16'he064;
    localparam int TAB_WORDS = 256;
    localparam logic [15:0] MAX_QTY_FRD = 16'h007d;
    localparam logic [15:0] MAX_QTY_RDWR = 16'h0076;
    localparam logic [31:0] RESET_FLOAT = 32'h0000_0000;

    // Byte stream carrier
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } mbf_byte_type;

endpackage

/* File: src/mbf_regfile.sv */
// Purpose: Storage of the 16-bit registers behind the float table
// Assumes: One write port, one combinational read port
// Notes: Floats are stored as high/low 16-bit register pairs
`timescale 1ns/10ps
module mbf_regfile import mbf_pkg::*; #(
    parameter int WORDS = TAB_WORDS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Write port
    input wire logic wr_en,
    input wire logic [15:0] wr_addr,
    input wire logic [15:0] wr_data,
    // Read port
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data,
    output logic rd_hit
);
    // ************************************************************
    // Storage
    // ************************************************************
    logic [15:0] mem_q [WORDS];
    logic [15:0] mem_d [WORDS];

    // True when the address falls within the table window
    function automatic logic in_tab(input logic [15:0] a);
        return (a >= TAB_BASE) && (a < TAB_BASE + 16'(WORDS));
    endfunction

    // Next-state of every word
    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (wr_en && in_tab(wr_addr)) begin
            mem_d[8'(wr_addr - TAB_BASE)] = wr_data;
        end
    end

    // Registers; floats reset to zero encoding
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < WORDS; i++) begin
            if (!resetn) begin
                mem_q[i] <= RESET_FLOAT[15:0];
            end else begin
                mem_q[i] <= mem_d[i];
            end
        end
    end

    // Read side
    assign rd_hit = in_tab(rd_addr);
    assign rd_data = rd_hit ? mem_q[8'(rd_addr - TAB_BASE)] : 16'h0000;

endmodule // mbf_regfile

/* File: tb/mbf_handler_sva.sv */
// Purpose: Port-level checks on the float register handler
// Assumes: One clock domain, synchronous active-low reset
// Notes: Sees only the ports of mbf_handler; bound from the testbench
`timescale 1ns/10ps
module mbf_handler_sva import mbf_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Streams and status
    input wire mbf_byte_type req,
    input wire mbf_byte_type rsp,
    input wire logic busy
);
    // ************************************************************
    // Helper state
    // ************************************************************
    logic [7:0] fc_q; // Function code of the latest request
    logic mid_q; // Inside a request, past its first byte
    logic vld_q; // Response valid one cycle ago
    logic start; // First byte of a response
    assign start = rsp.valid && !vld_q;
    // Track request framing; refused bytes while busy are skipped
    always_ff @(posedge core_clk) begin
        vld_q <= resetn && rsp.valid;
        if (!resetn) begin
            fc_q <= 8'h00;
            mid_q <= 1'b0;
        end else if (req.valid && !busy) begin
            if (!mid_q) begin
                fc_q <= req.data;
            end
            mid_q <= !req.last;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ************************************************************
    // Properties
    // ************************************************************
    // Reset must hold the outputs quiet, so it overrides the default
    property p_rst;
        disable iff (1'b0) !resetn |=> !rsp.valid && !busy;
    endproperty
    // No answer before the request has been acted on
    property p_gap;
        req.valid && req.last && !busy |=> busy && !rsp.valid ##1 !rsp.valid;
    endproperty
    property p_err;
        start && rsp.data[7] |=> rsp.valid && rsp.last;
    endproperty
    property p_code;
        start |-> rsp.data[6:0] == fc_q[6:0];
    endproperty
    property p_even;
        start && (rsp.data == FC_FRD || rsp.data == FC_RDWR)
            |=> rsp.valid && !rsp.data[0];
    endproperty
    property p_flow;
        rsp.valid && !rsp.last |=> rsp.valid;
    endproperty
    property p_end;
        rsp.valid && rsp.last |=> !rsp.valid;
    endproperty
    // An echo of a float write is seven bytes: code, address, two words
    property p_echo;
        start && rsp.data == FC_FWR
            |=> (rsp.valid && !rsp.last)[*5] ##1 (rsp.valid && rsp.last);
    endproperty
    a_rst: assert property (p_rst) else $error("outputs active in reset");
    a_gap: assert property (p_gap) else $error("early answer");
    a_err: assert property (p_err) else $error("bad error frame");
    a_code: assert property (p_code) else $error("wrong code");
    a_even: assert property (p_even) else $error("odd count");
    a_flow: assert property (p_flow) else $error("gap in reply");
    a_end: assert property (p_end) else $error("reply overrun");
    a_echo: assert property (p_echo) else $error("echo length");
    c_err: cover property (start && rsp.data[7]);
    c_fwr: cover property (start && rsp.data == FC_FWR);
    c_rdwr: cover property (start && rsp.data == FC_RDWR);
endmodule // mbf_handler_sva

/* File: tb/mbf_client.sv */
// Purpose: Behavioural remote client that sends request frames
// Assumes: Handler takes one byte per clock while not busy
// Notes: Idle data shows the inverse of the last byte, never a stale copy
`timescale 1ns/10ps
module mbf_client import mbf_pkg::*; (
    // Clock
    input wire logic core_clk,
    // Streams
    output mbf_byte_type req,
    input wire mbf_byte_type rsp
);
    initial req = '0;
    // Send one frame, then gather the reply under a bounded wait
    task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$]);
        int n;
        rx = {};
        // Fields go high byte first
        foreach (tx[i]) begin
            @(posedge core_clk);
            req <= '{valid: 1'b1, last: (i == tx.size() - 1), data: tx[i]};
        end
        @(posedge core_clk);
        req <= '{valid: 1'b0, last: 1'b0, data: ~tx[tx.size() - 1]};
        n = 0;
        while (n < 600) begin
            @(posedge core_clk);
            n++;
            if (rsp.valid) begin
                rx.push_back(rsp.data);
            end
            if (rsp.valid && rsp.last) begin
                n = 600;
            end
        end
        // Idle gap before the next request
        repeat (2) @(posedge core_clk);
    endtask
endmodule // mbf_client

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the float register handler
// Assumes: Table words reset to zero, addresses are zero-based
// Notes: Each call sends a frame and compares the whole reply
`timescale 1ns/10ps
module tb import mbf_pkg::*;;
    logic core_clk = 1'b0; // 100 MHz clock
    logic resetn; // Synchronous reset
    mbf_byte_type req; // Request stream
    mbf_byte_type rsp; // Response stream
    logic busy; // Handler status
    int mismatches = 0;
    int num_checks = 0;
    always #5 core_clk = ~core_clk;
    mbf_handler i_dut (.core_clk(core_clk), .resetn(resetn), .req(req),
        .rsp(rsp), .busy(busy));
    mbf_client i_cli (.core_clk(core_clk), .req(req), .rsp(rsp));
    // Send a frame and compare the reply byte for byte
    task automatic chk(input logic [7:0] q[$], input logic [7:0] e[$]);
        logic [7:0] g[$];
        i_cli.xfer(q, g);
        num_checks++;
        if (g.size() != e.size()) begin
            mismatches++;
            $display("unexpected %0t len %0h %0h", $time, g.size(), e.size());
        end else begin
            foreach (e[i]) begin
                if (g[i] !== e[i]) begin
                    mismatches++;
                    $display("unexpected %0t %0h %0h", $time, g[i], e[i]);
                end
            end
        end
    endtask
    // Print the counts and the verdict, then end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        stop_test();
    end
    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        logic [7:0] e[$];
        logic [15:0] w;
        resetn <= 1'b0;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        chk('{FC_FRD, 8'he0, 8'h64, 8'h00, 8'h02},
            '{FC_FRD, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00});
        chk('{FC_FWR, 8'he0, 8'h64, 8'h3f, 8'hc0, 8'h00, 8'h00},
            '{FC_FWR, 8'he0, 8'h64, 8'h3f, 8'hc0, 8'h00, 8'h00});
        chk('{FC_FRD, 8'he0, 8'h64, 8'h00, 8'h02},
            '{FC_FRD, 8'h04, 8'h3f, 8'hc0, 8'h00, 8'h00});
        chk('{FC_FRD, 8'he0, 8'h63, 8'h00, 8'h02},
            '{FC_FRD, 8'h04, 8'h00, 8'h00, 8'h3f, 8'hc0});
        chk('{FC_RDWR, 8'he0, 8'h64, 8'h00, 8'h02, 8'he0, 8'h64, 8'h00,
            8'h02, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78},
            '{FC_RDWR, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78});
        // Largest float read: the whole reply is 252 bytes
        e = '{FC_FRD, 8'hfa};
        for (int i = 0; i < 125; i++) begin
            w = (i == 100) ? 16'h1234 : (i == 101) ? 16'h5678 : 16'h0000;
            e.push_back(w[15:8]);
            e.push_back(w[7:0]);
        end
        chk('{FC_FRD, 8'he0, 8'h00, 8'h00, 8'h7d}, e);
        chk('{8'h42, 8'h00}, '{8'hc2, EXC_FUNC});
        chk('{FC_FRD, 8'he0, 8'h64, 8'h00, 8'h00},
            '{FC_FRD | ERR_BIT, EXC_VALUE});
        chk('{FC_FRD, 8'he0, 8'h00, 8'h00, 8'h7e},
            '{FC_FRD | ERR_BIT, EXC_VALUE});
        // Byte count disagrees with the write quantity
        chk('{FC_RDWR, 8'he0, 8'h64, 8'h00, 8'h01, 8'he0, 8'h64, 8'h00,
            8'h01, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78},
            '{FC_RDWR | ERR_BIT, EXC_VALUE});
        stop_test();
    end
endmodule // tb
bind mbf_handler mbf_handler_sva i_sva (.core_clk(core_clk),
    .resetn(resetn), .req(req), .rsp(rsp), .busy(busy));
